// >>> rtl/dvhdr_map.svh
// dvhdr_map.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the register bank and its helpers
`ifndef DVHDR_MAP_SVH
`define DVHDR_MAP_SVH
// register offsets on the control port
`define DVHDR_LEFT_GAIN_OFS 8'h41
`define DVHDR_RIGHT_GAIN_OFS 8'h42
`define DVHDR_JACK_OFS 8'h43
`define DVHDR_COMP1_OFS 8'h44
// reset values
`define DVHDR_GAIN_RST 8'h00
`define DVHDR_JACK_RST 8'h00
`define DVHDR_COMP1_RST 8'h0F
// writable bits of the jack register, status bits masked out
`define DVHDR_JACK_WR_MASK 8'h9F
// field positions
`define DVHDR_JACK_EN_BIT 7
`define DVHDR_JACK_DB_LSB 2
`define DVHDR_COMP_LEFT_BIT 6
`define DVHDR_COMP_RIGHT_BIT 5
`define DVHDR_COMP_THR_LSB 2
// gain code limits, half-decibel units
`define DVHDR_GAIN_MAX 8'h30
`define DVHDR_GAIN_RSV 8'h80
`define DVHDR_GAIN_MIN 8'h81
// compressor threshold step in dB
`define DVHDR_THR_STEP_DB 5'h03
// debounce timing
`define DVHDR_REF_HZ 1000000
`define DVHDR_MS_PER_S 1000
`define DVHDR_REF_PER_MS (`DVHDR_REF_HZ / `DVHDR_MS_PER_S)
`define DVHDR_JACK_DB_MAX 3'h5
`define DVHDR_SAMPLES 8
`endif

// >>> rtl/dvhdr_pkg.sv
// dvhdr_pkg: types shared by the register bank and its helpers
// assumes: nothing; holds types only
package dvhdr_pkg;
    typedef logic signed [7:0] dvhdr_gain_type;
    // headset status codes
    typedef enum logic [1:0] {
        JACK_NONE = 2'h0,
        JACK_NO_MIC = 2'h1,
        JACK_RSV = 2'h2,
        JACK_MIC = 2'h3
    } dvhdr_jack_type;
    // volume soft-step modes
    typedef enum logic [1:0] {
        STEP_EVERY = 2'h0,
        STEP_EVERY_TWO = 2'h1,
        STEP_OFF = 2'h2,
        STEP_RSV = 2'h3
    } dvhdr_step_mode_type;
endpackage

// >>> rtl/dvhdr_step_if.sv
// dvhdr_step_if: target and applied gain between bank and one stepper
// assumes: all signals on ref_clk
`timescale 1ns/10ps
`default_nettype none
interface dvhdr_step_if;
    logic fs_tick;
    dvhdr_pkg::dvhdr_step_mode_type step_mode;
    dvhdr_pkg::dvhdr_gain_type target;
    dvhdr_pkg::dvhdr_gain_type applied;
    modport stepper (input fs_tick, input step_mode, input target, output applied);
    modport owner (output fs_tick, output step_mode, output target, input applied);
endinterface
`default_nettype wire

// >>> rtl/dvhdr_vol_step.sv
// dvhdr_vol_step: walks the applied gain toward the target code
// assumes: fs_tick is a one-cycle pulse per sample on ref_clk
`timescale 1ns/10ps
`default_nettype none
module dvhdr_vol_step (
    input wire logic ref_clk, // system clock
    input wire logic rst_n, // sync reset
    dvhdr_step_if.stepper sif // target in, applied out
);
    typedef struct packed {
        logic signed [7:0] applied;
        logic skip;
    } dvhdr_step_state_type;
    dvhdr_step_state_type cur, next_cur;
    logic due;

    always_comb begin
        next_cur = cur;
        due = sif.fs_tick && !(sif.step_mode == dvhdr_pkg::STEP_EVERY_TWO && cur.skip);
        if (sif.fs_tick) begin
            next_cur.skip = !cur.skip;
        end
        if (sif.step_mode == dvhdr_pkg::STEP_OFF) begin
            next_cur.applied = sif.target;
        // one code per step, either direction
        end else if (due && cur.applied < sif.target) begin
            next_cur.applied = cur.applied + 8'sh01;
        end else if (due && cur.applied > sif.target) begin
            next_cur.applied = cur.applied - 8'sh01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cur <= '{applied: 8'sh00, skip: 1'b0};
        end else begin
            cur <= next_cur;
        end
    end
    assign sif.applied = cur.applied;

    sequence s_step_due;
        due && sif.step_mode != dvhdr_pkg::STEP_OFF && cur.applied != sif.target;
    endsequence
    sequence s_one_step;
        cur.applied == $past(cur.applied) + 8'sh01 || cur.applied == $past(cur.applied) - 8'sh01;
    endsequence
    a_step_half_db: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_step_due |=> s_one_step) else $error("gain step is not one code");
    a_step_only_tick: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !sif.fs_tick && sif.step_mode != dvhdr_pkg::STEP_OFF |=> $stable(cur.applied))
        else $error("gain moved without a sample tick");
    a_step_off_jump: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sif.step_mode == dvhdr_pkg::STEP_OFF |=> cur.applied == $past(sif.target))
        else $error("unstepped gain did not follow target");
    a_step_skip_two: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sif.fs_tick && sif.step_mode == dvhdr_pkg::STEP_EVERY_TWO && cur.skip |=> $stable(cur.applied))
        else $error("gain stepped on a skipped sample");
endmodule // dvhdr_vol_step
`default_nettype wire

// >>> rtl/dvhdr_debounce.sv
// dvhdr_debounce: accepts a level on the ninth equal sample in a row (first one captures, eight more match)
// assumes: ms_tick is a one-cycle pulse per millisecond on ref_clk
`timescale 1ns/10ps
`default_nettype none
`include "dvhdr_map.svh"
module dvhdr_debounce #(
    parameter int WIDTH = 2,
    parameter int MSW = 7
) (
    input wire logic ref_clk, // system clock
    input wire logic rst_n, // sync reset, also held while detection is off
    input wire logic ms_tick, // millisecond pulse
    input wire logic bypass, // zero debounce time
    input wire logic [MSW-1:0] sample_ms, // sample period in ms
    input wire logic [WIDTH-1:0] raw, // synchronised level
    output logic [WIDTH-1:0] stable // accepted level
);
    typedef struct packed {
        logic [MSW-1:0] ms_cnt;
        logic [2:0] same;
        logic [WIDTH-1:0] cand;
        logic [WIDTH-1:0] stable;
    } dvhdr_db_state_type;
    dvhdr_db_state_type cur, next_cur;

    always_comb begin
        next_cur = cur;
        if (bypass) begin
            next_cur.stable = raw;
            next_cur.cand = raw;
            next_cur.ms_cnt = '0;
            next_cur.same = 3'h0;
        end else if (ms_tick) begin
            next_cur.ms_cnt = cur.ms_cnt + {{(MSW-1){1'b0}}, 1'b1};
            if (next_cur.ms_cnt >= sample_ms) begin
                next_cur.ms_cnt = '0;
                if (raw != cur.cand) begin
                    next_cur.cand = raw;
                    next_cur.same = 3'h0;
                end else if (cur.same == 3'(`DVHDR_SAMPLES - 1)) begin
                    next_cur.stable = cur.cand;
                end else begin
                    next_cur.same = cur.same + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end
    assign stable = cur.stable;

    a_db_bypass: assert property (@(posedge ref_clk) disable iff (!rst_n)
        bypass |=> stable == $past(raw)) else $error("bypassed level not passed");
endmodule // dvhdr_debounce
`default_nettype wire

// >>> rtl/dvhdr_regs.sv
// dvhdr_regs: DAC volume, headset detection and first compressor register bank
// assumes: the control-bus slave gives one-cycle write and read strobes on ref_clk;
// ref_tick_1mhz and fs_tick are one-cycle pulses made elsewhere on ref_clk;
// jack, mic and button senses come straight from pins.
`timescale 1ns/10ps
`default_nettype none
`include "dvhdr_map.svh"
module dvhdr_regs (
    input wire logic ref_clk, // 25 MHz system clock
    input wire logic rst_n, // sync reset, active low
    input wire logic [7:0] reg_addr, // register offset
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [7:0] reg_wdata, // write data
    output logic [7:0] reg_rdata, // read data, cycle after reg_rd
    output logic reg_rvalid, // read data valid pulse
    input wire logic ref_tick_1mhz, // 1 MHz reference pulse
    input wire logic fs_tick, // DAC word clock pulse
    input wire logic [1:0] step_mode, // volume soft-step mode
    input wire logic [1:0] volume_link, // volume linking field
    input wire logic jack_sense, // plug inserted, pin
    input wire logic mic_sense, // plug has microphone, pin
    input wire logic button_sense, // button held, pin
    output logic signed [7:0] left_gain, // applied left gain, half dB
    output logic signed [7:0] right_gain, // applied right gain, half dB
    output logic comp_left_en, // left compression active
    output logic comp_right_en, // right compression active
    output logic [4:0] comp_threshold_below_db, // threshold, dB below full scale
    output logic [1:0] comp_hysteresis_db, // hysteresis in dB
    output logic [1:0] jack_status, // debounced headset status
    output logic button_pressed, // debounced button level
    output logic jack_event, // status change pulse while detection is on
    output logic button_event // button press pulse
);
    typedef struct packed {
        logic [7:0] left;
        logic [7:0] right;
        logic [7:0] jack_ctl;
        logic [7:0] comp1;
        logic [7:0] rdata;
        logic rvalid;
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [9:0] ref_cnt;
        logic ms_tick;
        logic [1:0] status;
        logic btn;
        logic jack_ev;
        logic btn_ev;
        logic cl;
        logic cr;
        logic [4:0] thr;
        logic [1:0] hyst;
    } dvhdr_bank_state_type;
    dvhdr_bank_state_type cur, next_cur;

    dvhdr_step_if left_if ();
    dvhdr_step_if right_if ();
    logic [1:0] jack_stable;
    logic btn_stable;
    logic det_en;
    logic det_rst_n;
    logic [2:0] jack_db;
    logic [1:0] btn_db;
    logic [6:0] jack_ms;
    logic [6:0] btn_ms;
    logic comp_any;

    // keep the gain inside the legal code range even if the host errs
    // spare 0x80 folds onto the lowest code
    // bit 7 set marks a negative two's-complement code
    function automatic logic [7:0] clamp_gain(input logic [7:0] c);
        if (!c[7] && c > `DVHDR_GAIN_MAX) begin
            return `DVHDR_GAIN_MAX;
        end else if (c == `DVHDR_GAIN_RSV) begin
            return `DVHDR_GAIN_MIN;
        end
        return c;
    endfunction

    // control fields
    assign det_en = cur.jack_ctl[`DVHDR_JACK_EN_BIT];
    assign jack_db = cur.jack_ctl[`DVHDR_JACK_DB_LSB +: 3];
    assign btn_db = cur.jack_ctl[1:0];
    assign comp_any = cur.comp1[`DVHDR_COMP_LEFT_BIT] | cur.comp1[`DVHDR_COMP_RIGHT_BIT];
    // detection held in reset while off
    assign det_rst_n = rst_n & det_en;

    // sample period 2 ms doubled per code; reserved codes use the longest
    always_comb begin
        jack_ms = 7'h02 << ((jack_db > `DVHDR_JACK_DB_MAX) ? `DVHDR_JACK_DB_MAX : jack_db);
    end
    // button sample period 1, 2 or 4 ms
    assign btn_ms = 7'h01 << (btn_db - 2'h1);

    always_comb begin
        left_if.target = clamp_gain(cur.left);
        right_if.target = clamp_gain(cur.right);
        if (!comp_any && volume_link == 2'h1) begin
            left_if.target = clamp_gain(cur.right);
        end else if (!comp_any && volume_link == 2'h2) begin
            right_if.target = clamp_gain(cur.left);
        end
    end
    assign left_if.fs_tick = fs_tick;
    assign right_if.fs_tick = fs_tick;
    assign left_if.step_mode = dvhdr_pkg::dvhdr_step_mode_type'(step_mode);
    assign right_if.step_mode = dvhdr_pkg::dvhdr_step_mode_type'(step_mode);

    dvhdr_vol_step u_left_step (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sif(left_if.stepper)
    );
    dvhdr_vol_step u_right_step (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sif(right_if.stepper)
    );

    // headset debounce, raw code never forms the reserved pattern
    dvhdr_debounce #(.WIDTH(2), .MSW(7)) u_jack_db (
        .ref_clk(ref_clk),
        .rst_n(det_rst_n),
        .ms_tick(cur.ms_tick),
        .bypass(1'b0),
        .sample_ms(jack_ms),
        .raw({cur.sync2[0] & cur.sync2[1], cur.sync2[0]}),
        .stable(jack_stable)
    );
    // button debounce, code 00 passes through
    dvhdr_debounce #(.WIDTH(1), .MSW(7)) u_btn_db (
        .ref_clk(ref_clk),
        .rst_n(det_rst_n),
        .ms_tick(cur.ms_tick),
        .bypass(btn_db == 2'h0),
        .sample_ms(btn_ms),
        .raw(cur.sync2[2]),
        .stable(btn_stable)
    );

    // register writes, reads, tick and status
    always_comb begin
        next_cur = cur;
        next_cur.rvalid = reg_rd;
        next_cur.jack_ev = 1'b0;
        next_cur.btn_ev = 1'b0;
        next_cur.ms_tick = 1'b0;
        // pins pass two flops before use
        next_cur.sync1 = {button_sense, mic_sense, jack_sense};
        next_cur.sync2 = cur.sync1;
        if (ref_tick_1mhz) begin
            if (cur.ref_cnt == 10'(`DVHDR_REF_PER_MS - 1)) begin
                next_cur.ref_cnt = 10'h000;
                next_cur.ms_tick = 1'b1;
            end else begin
                next_cur.ref_cnt = cur.ref_cnt + 10'h001;
            end
        end
        if (reg_wr && reg_addr == `DVHDR_LEFT_GAIN_OFS) begin
            next_cur.left = reg_wdata;
        end else if (reg_wr && reg_addr == `DVHDR_RIGHT_GAIN_OFS) begin
            next_cur.right = reg_wdata;
        end else if (reg_wr && reg_addr == `DVHDR_JACK_OFS) begin
            next_cur.jack_ctl = reg_wdata & `DVHDR_JACK_WR_MASK;
        end else if (reg_wr && reg_addr == `DVHDR_COMP1_OFS) begin
            next_cur.comp1 = reg_wdata;
        end
        if (reg_rd && reg_addr == `DVHDR_LEFT_GAIN_OFS) begin
            next_cur.rdata = cur.left;
        end else if (reg_rd && reg_addr == `DVHDR_RIGHT_GAIN_OFS) begin
            next_cur.rdata = cur.right;
        end else if (reg_rd && reg_addr == `DVHDR_JACK_OFS) begin
            next_cur.rdata = {cur.jack_ctl[7], cur.status, cur.jack_ctl[4:0]};
        end else if (reg_rd && reg_addr == `DVHDR_COMP1_OFS) begin
            next_cur.rdata = cur.comp1;
        end else if (reg_rd) begin
            next_cur.rdata = 8'h00;
        end
        next_cur.status = det_en ? jack_stable : dvhdr_pkg::JACK_NONE;
        next_cur.btn = det_en & btn_stable;
        next_cur.jack_ev = det_en && (jack_stable != cur.status);
        next_cur.btn_ev = det_en && btn_stable && !cur.btn;
        next_cur.cl = cur.comp1[`DVHDR_COMP_LEFT_BIT];
        next_cur.cr = cur.comp1[`DVHDR_COMP_RIGHT_BIT];
        // threshold in 3 dB steps from -3 dB
        next_cur.thr = 5'(`DVHDR_THR_STEP_DB * ({2'h0, cur.comp1[`DVHDR_COMP_THR_LSB +: 3]} + 5'h01));
        next_cur.hyst = cur.comp1[1:0];
    end

    // register the whole bank; reset values are the documented ones
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cur <= '0;
            cur.left <= `DVHDR_GAIN_RST;
            cur.right <= `DVHDR_GAIN_RST;
            cur.jack_ctl <= `DVHDR_JACK_RST;
            cur.comp1 <= `DVHDR_COMP1_RST;
            cur.thr <= 5'h0C;
            cur.hyst <= 2'h3;
        end else begin
            cur <= next_cur;
        end
    end

    // outputs
    assign reg_rdata = cur.rdata;
    assign reg_rvalid = cur.rvalid;
    assign left_gain = left_if.applied;
    assign right_gain = right_if.applied;
    assign comp_left_en = cur.cl;
    assign comp_right_en = cur.cr;
    assign comp_threshold_below_db = cur.thr;
    assign comp_hysteresis_db = cur.hyst;
    assign jack_status = cur.status;
    assign button_pressed = cur.btn;
    assign jack_event = cur.jack_ev;
    assign button_event = cur.btn_ev;

    default clocking dvhdr_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_disable_write;
        reg_wr && reg_addr == `DVHDR_JACK_OFS && !reg_wdata[`DVHDR_JACK_EN_BIT];
    endsequence
    sequence s_status_cleared;
        ##2 jack_status == 2'h0 && !button_pressed;
    endsequence
    a_left_gain_max: assert property (left_gain <= 8'sh30)
        else $error("left gain above +24 dB");
    a_left_gain_min: assert property (left_gain >= -8'sh7F)
        else $error("left gain below -63.5 dB");
    a_right_gain_range: assert property (right_gain <= 8'sh30 && right_gain >= -8'sh7F)
        else $error("right gain out of range");
    a_gain_reset_unity: assert property (!$past(rst_n) |-> left_gain == 8'sh00 && right_gain == 8'sh00)
        else $error("gain not unity after reset");
    a_right_neg_step: assert property (fs_tick && step_mode == 2'h0 && right_gain == 8'sh00
        && right_if.target == 8'shFF |=> right_gain == -8'sh01) else $error("right gain not -0.5 dB");
    a_status_legal: assert property (jack_status != 2'h2)
        else $error("reserved headset status shown");
    a_detect_off_none: assert property (s_disable_write |-> s_status_cleared)
        else $error("status not cleared after disable");
    a_ms_from_ref: assert property (cur.ms_tick |-> $past(ref_tick_1mhz))
        else $error("millisecond tick without reference tick");
    a_comp_left_gate: assert property (comp_left_en |-> $past(cur.comp1[`DVHDR_COMP_LEFT_BIT]))
        else $error("left compression without enable");
    a_comp_right_gate: assert property (comp_right_en |-> $past(cur.comp1[`DVHDR_COMP_RIGHT_BIT]))
        else $error("right compression without enable");
    a_threshold_step: assert property (##1 comp_threshold_below_db
        == 5'(3 * ({2'h0, $past(cur.comp1[4:2])} + 5'h01))) else $error("threshold mismatch");
    a_hyst_follow: assert property (##1 comp_hysteresis_db == $past(cur.comp1[1:0]))
        else $error("hysteresis mismatch");
    a_link_indep: assert property (comp_any |-> left_if.target == clamp_gain(cur.left))
        else $error("volume linked while compressing");
    a_jack_sample_ms: assert property (jack_db == 3'h0 |-> jack_ms == 7'h02)
        else $error("wrong headset sample period");
    sequence s_read_issue;
        reg_rd;
    endsequence
    a_read_valid_next: assert property (s_read_issue |=> reg_rvalid)
        else $error("read data not flagged valid");
    a_jack_ro_bits: assert property (reg_wr && reg_addr == `DVHDR_JACK_OFS |=> cur.jack_ctl[6:5] == 2'h0)
        else $error("headset status bits were stored");
    a_jack_event_change: assert property (jack_event |-> jack_status != $past(jack_status))
        else $error("headset event without status change");
    a_button_event_rise: assert property (button_event |-> button_pressed && !$past(button_pressed))
        else $error("button event without press edge");
endmodule // dvhdr_regs
`default_nettype wire

// >>> verification/dvhdr_host.sv
// dvhdr_host: host model driving the register port of the bank
// assumes: ref_clk from the bench; requests change 1 ns after rising edges
`timescale 1ns/10ps
`default_nettype none
module dvhdr_host (
    input wire logic ref_clk, // system clock
    input wire logic [7:0] reg_rdata, // read data
    input wire logic reg_rvalid, // read data valid
    output logic [7:0] reg_addr, // register offset
    output logic reg_wr, // write strobe
    output logic reg_rd, // read strobe
    output logic [7:0] reg_wdata, // write data
    output logic [1:0] volume_link // volume linking field
);
    // idle port at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
        volume_link = 2'h0;
    end
    // one-cycle write strobe, data scrambled once the edge has taken it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if ((a == 8'h41 || a == 8'h42) && (d == 8'h80 || $signed(d) > 48)) d = 8'h30;
        if (a == 8'h44) d[7] = 1'b0;
        @(posedge ref_clk);
        #1;
        if (a == 8'h44 && d[6:5] != 2'h0) volume_link = 2'h0;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    // one-cycle read strobe; data taken when valid shows, bounded wait
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(posedge ref_clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge ref_clk);
        #1;
        reg_rd = 1'b0;
        for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) begin
            @(posedge ref_clk);
            #1;
        end
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
    endtask
    // linking field lives in another register of the host's
    task automatic link(input logic [1:0] l);
        @(posedge ref_clk);
        #1;
        volume_link = l;
    endtask
endmodule // dvhdr_host
`default_nettype wire

// >>> verification/tb.sv
// tb: self-checking bench for the volume, headset and compressor bank
// assumes: 1 MHz reference tick held high, so 1 ms is 1000 clocks
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic ref_clk, rst_n, fs_tick, jack_sense, mic_sense, button_sense;
    logic [1:0] step_mode, volume_link, comp_hysteresis_db, jack_status;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, code;
    logic reg_wr, reg_rd, reg_rvalid, comp_left_en, comp_right_en;
    logic button_pressed, jack_event, button_event;
    logic signed [7:0] left_gain, right_gain;
    logic [4:0] comp_threshold_below_db;
    logic [7:0] m_reg [4];
    int err_total, n_compared, cycles, seed, i;
    dvhdr_regs dut (.ref_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .reg_rvalid, .ref_tick_1mhz(1'b1), .fs_tick, .step_mode, .volume_link, .jack_sense,
        .mic_sense, .button_sense, .left_gain, .right_gain, .comp_left_en, .comp_right_en,
        .comp_threshold_below_db, .comp_hysteresis_db, .jack_status, .button_pressed,
        .jack_event, .button_event);
    dvhdr_host host (.ref_clk, .reg_rdata, .reg_rvalid, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .volume_link);
    // free-running 25 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // hang guard well beyond the longest debounce
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 80000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // main sequence
    initial begin
        seed = 75;
        err_total = 0;
        n_compared = 0;
        cycles = 0;
        rst_n = 1'b0;
        fs_tick = 1'b0;
        step_mode = 2'h2;
        jack_sense = 1'b0;
        mic_sense = 1'b0;
        button_sense = 1'b0;
        m_reg = '{8'h00, 8'h00, 8'h00, 8'h0F};
        tick(12);
        rst_n = 1'b1;
        // reset values, one unmapped offset at the end
        for (i = 0; i < 5; i++) begin
            host.rd(8'h41 + 8'(i), rv);
            check("reset read", rv, i < 4 ? m_reg[i] : 8'h00);
        end
        check("threshold", comp_threshold_below_db, 8'h0C);
        check("hysteresis", comp_hysteresis_db, 8'h03);
        check("comp en", {comp_left_en, comp_right_en}, 8'h00);
        check("left gain", left_gain, 8'h00);
        // jump mode: limits, minus half dB, then random legal codes
        for (i = 0; i < 8; i++) begin
            code = i == 0 ? 8'h30 : i == 1 ? 8'hFF : i == 2 ? 8'h81 :
                8'($unsigned($random(seed)) % 176 - 127);
            host.wr(8'h41 + 8'(i[0]), code);
            m_reg[i[0]] = code;
            tick(3);
            check("gain", i[0] ? right_gain : left_gain, code);
            host.rd(8'h41 + 8'(i[0]), rv);
            check("gain read", rv, code);
        end
        // linked left follows right until compression unlinks it
        host.link(2'h1);
        tick(3);
        check("linked", left_gain, m_reg[1]);
        host.wr(8'h44, 8'h4F);
        tick(3);
        check("unlinked", left_gain, m_reg[0]);
        // every threshold code with random enables and hysteresis
        for (i = 0; i < 8; i++) begin
            code = {1'b0, 2'($random(seed)), i[2:0], 2'($random(seed))};
            host.wr(8'h44, code);
            tick(3);
            check("threshold", comp_threshold_below_db, 8'(3 * i + 3));
            check("hysteresis", comp_hysteresis_db, code[1:0]);
            check("comp en", {comp_left_en, comp_right_en}, code[6:5]);
            host.rd(8'h44, rv);
            check("comp read", rv, code);
        end
        // soft step: one half-dB step per sample pulse; right goes down once
        host.wr(8'h41, 8'h00);
        host.wr(8'h42, 8'h00);
        tick(3);
        step_mode = 2'h0;
        host.wr(8'h41, 8'h02);
        host.wr(8'h42, 8'hFF);
        for (i = 1; i < 4; i++) begin
            fs_tick = 1'b1;
            tick(1);
            fs_tick = 1'b0;
            tick(2);
            check("step", left_gain, i < 3 ? 8'(i) : 8'h02);
            check("right step", right_gain, 8'hFF);
        end
        // one step per two sample pulses, whatever the phase
        step_mode = 2'h1;
        host.wr(8'h41, 8'h00);
        for (i = 1; i < 5; i++) begin
            fs_tick = 1'b1;
            tick(1);
            fs_tick = 1'b0;
            tick(2);
            if (i % 2 == 0) check("two step", left_gain, 8'(2 - i / 2));
        end
        // headset with mic, 16 ms debounce sampled every 2 ms
        jack_sense = 1'b1;
        mic_sense = 1'b1;
        host.wr(8'h43, 8'h80);
        tick(12000);
        check("early status", jack_status, 8'h00);
        for (i = 0; i < 8000 && jack_event !== 1'b1; i++) tick(1);
        check("jack window", 8'(i >= 3900 && i <= 6100), 8'h01);
        check("status", jack_status, 8'h03);
        host.rd(8'h43, rv);
        check("jack read", rv, 8'hE0);
        // button 8 ms debounce sampled every 1 ms
        host.wr(8'h43, 8'h81);
        button_sense = 1'b1;
        for (i = 0; i < 10000 && button_event !== 1'b1; i++) tick(1);
        check("button window", 8'(i >= 7900 && i <= 9100), 8'h01);
        check("button", button_pressed, 8'h01);
        // disable while writing the status bits: nothing inserted
        host.wr(8'h43, 8'h60);
        tick(3);
        check("off status", jack_status, 8'h00);
        host.rd(8'h43, rv);
        check("off read", rv, 8'h00);
        // reset in mid-run brings back every documented value
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        host.rd(8'h44, rv);
        check("comp after reset", rv, 8'h0F);
        check("threshold after reset", comp_threshold_below_db, 8'h0C);
        check("gain after reset", left_gain, 8'h00);
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
